/* File: hdl/adc_ctrl_pkg.sv */
// Constants shared by the converter control block and its bit-decision engine.
// Assumes a single 250 MHz clock and a comparator fed by the analog front end.
//
// Overview of operation
// - Above upper reference gives all ones result.
// - Below lower reference gives zero result.
// - Three-bit field selects the converted channel.
// - Converter-on starts continuous back-to-back conversions.
// - Conversion end sets flag, loads result registers.
// - High-byte read or control write clears flag.
// - Channel change aborts, clears flag, restarts conversion.
// - Clearing converter-on stops conversions, saves power.
// - Wait mode leaves converter running.
// - Halt disables converter; settle after wake.
package adc_ctrl_pkg;
	localparam int RES_BITS     = 10;
	localparam int CH_BITS      = 3;
	localparam int CH_POS       = 0;
	localparam int EOC_POS      = 7;
	localparam int ON_POS       = 5;
	localparam logic [7:0] CSR_RESET   = 8'h00;
	localparam logic [7:0] HIGH_FULL   = 8'hff;
	localparam logic [1:0] LOW_FULL    = 2'h3;
	localparam int SAMPLE_NS    = 200;
	localparam int CLK_NS       = 4;
	localparam int SAMPLE_CYC   = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
	localparam int BIT_CYC      = 4;
	localparam int SETTLE_NS    = 20000;
	localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* File: hdl/sar_bus_if.sv */
// Link between control and bit-decision engine; same clock both sides.
interface sar_bus_if;
	logic                 start;
	logic                 abort;
	logic                 cmpHigh;
	logic                 done;
	logic [9:0]           result;
	logic [9:0]           trial;
	logic                 sampling;
	modport ctrl (output start, output abort, input done, input result, input sampling);
	modport eng  (input start, input abort, input cmpHigh, output done, output result,
		output trial, output sampling);
endinterface

/* File: hdl/sar_engine.sv */
// Successive-approximation engine: sample, then ten bit decisions MSB first.
// Assumes the comparator input is already synchronised by the top.
module sar_engine
	import adc_ctrl_pkg::*;
#(
	parameter int SAMPLE_CYCLES = SAMPLE_CYC,
	parameter int BIT_CYCLES    = BIT_CYC
) (
	input  wire logic clk,
	input  wire logic rst,
	sar_bus_if.eng    bus
);
	// Under four bit cycles the decision outruns trial flop plus synchroniser
	if (SAMPLE_CYCLES < 1 || SAMPLE_CYCLES > 255 || BIT_CYCLES < 4 || BIT_CYCLES > 255) begin
		$error("sar_engine: cycle counts out of range");
	end

	typedef enum logic [2:0] {
		IDLE = 3'b001,
		SAMP = 3'b010,
		CONV = 3'b100
	} state_t;

	typedef struct packed {
		state_t     st;
		logic [7:0] cnt;
		logic [3:0] bitIdx;
		logic [9:0] acc;
		logic [9:0] res;
		logic       done;
	} eng_t;

	eng_t r_ff, nxt_r;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.done = 1'b0;
		case (r_ff.st)
			IDLE: begin
				if (bus.start) begin
					nxt_r.st  = SAMP;
					nxt_r.cnt = 8'(SAMPLE_CYCLES - 1);
				end
			end
			SAMP: begin
				if (r_ff.cnt == 8'h00) begin
					nxt_r.st     = CONV;
					nxt_r.cnt    = 8'(BIT_CYCLES - 1);
					nxt_r.bitIdx = 4'(RES_BITS - 1);
					nxt_r.acc    = 10'h200;
				end else begin
					nxt_r.cnt = r_ff.cnt - 8'h01;
				end
			end
			CONV: begin
				if (r_ff.cnt != 8'h00) begin
					nxt_r.cnt = r_ff.cnt - 8'h01;
				end else begin
					// Comparator high keeps trial bit; saturates to all ones or zero
					nxt_r.acc = r_ff.acc;
					if (!bus.cmpHigh)
						nxt_r.acc[r_ff.bitIdx] = 1'b0;
					if (r_ff.bitIdx == 4'h0) begin
						nxt_r.res  = nxt_r.acc;
						nxt_r.done = 1'b1;
						nxt_r.st   = IDLE;
					end else begin
						nxt_r.acc[r_ff.bitIdx - 4'h1] = 1'b1;
						nxt_r.bitIdx = r_ff.bitIdx - 4'h1;
						nxt_r.cnt    = 8'(BIT_CYCLES - 1);
					end
				end
			end
			default: nxt_r.st = IDLE;
		endcase
		if (bus.abort) begin
			nxt_r.st   = IDLE;
			nxt_r.done = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			r_ff <= '{st: IDLE, cnt: 8'h00, bitIdx: 4'h0, acc: 10'h000, res: 10'h000,
				done: 1'b0};
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign bus.done     = r_ff.done;
	assign bus.result   = r_ff.res;
	assign bus.trial    = r_ff.acc;
	assign bus.sampling = (r_ff.st == SAMP);
endmodule

/* File: hdl/adc_conversion_control.sv */
// Converter control: control/status register, result registers, mode handling.
// Assumes a CPU-side byte port on the same clock and an external comparator
// and multiplexer driven from the outputs here; comparator is asynchronous.
module adc_conversion_control
	import adc_ctrl_pkg::*;
#(
	parameter int SETTLE_CYCLES = SETTLE_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       csrWrite,
	input  wire logic [7:0] csrWdata,
	input  wire logic       csrRead,
	input  wire logic       highRead,
	input  wire logic       lowRead,
	input  wire logic       waitMode,
	input  wire logic       haltMode,
	input  wire logic       cmpHighAsync,
	output logic [7:0]      csrRdata,
	output logic [7:0]      resultHigh,
	output logic [7:0]      resultLow,
	output logic [2:0]      channelSel,
	output logic            converterPower,
	output logic            sampleHold,
	output logic [9:0]      dacTrial,
	output logic            resultSettled
);
	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin
		$error("adc_conversion_control: SETTLE_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic [1:0]  cmpSync;
		logic [2:0]  chan;
		logic        on;
		logic        eoc;
		logic        running;
		logic [15:0] settleCnt;
		logic [9:0]  res;
		logic        start;
		logic        abort;
		logic [7:0]  csrOut;
		logic [7:0]  hiOut;
		logic [7:0]  loOut;
		logic [9:0]  trialOut;
		logic        sampOut;
		logic        powerOut;
		logic        settled;
	} ctl_t;

	ctl_t r_ff, nxt_r;

	sar_bus_if bus ();

	assign bus.cmpHigh = r_ff.cmpSync[1];
	assign bus.start   = r_ff.start;
	assign bus.abort   = r_ff.abort;

	sar_engine #(
		.SAMPLE_CYCLES (SAMPLE_CYC),
		.BIT_CYCLES    (BIT_CYC)
	) engine (
		.clk (clk),
		.rst (rst),
		.bus (bus)
	);

	////////////////////////////////////////////////////////////////////////////

	logic enabled;
	logic chanChange;
	logic [7:0] csrView;

	always_comb begin
		// Wait mode is deliberately ignored; only halt gates the converter
		enabled    = r_ff.on && !haltMode;
		chanChange = csrWrite && (csrWdata[CH_POS +: CH_BITS] != r_ff.chan);
		csrView    = 8'h00;
		csrView[EOC_POS] = r_ff.eoc;
		csrView[ON_POS]  = r_ff.on;
		csrView[CH_POS +: CH_BITS] = r_ff.chan;
	end

	always_comb begin
		nxt_r = r_ff;
		nxt_r.cmpSync = {r_ff.cmpSync[0], cmpHighAsync};
		nxt_r.start   = 1'b0;
		nxt_r.abort   = 1'b0;

		if (csrWrite) begin
			nxt_r.chan = csrWdata[CH_POS +: CH_BITS];
			nxt_r.on   = csrWdata[ON_POS];
		end

		// Abort on channel change, power-off or halt entry
		if (r_ff.running && (chanChange || !enabled ||
				(csrWrite && !csrWdata[ON_POS]))) begin
			nxt_r.abort   = 1'b1;
			nxt_r.running = 1'b0;
		end else if (bus.done) begin
			nxt_r.res     = bus.result;
			nxt_r.running = 1'b0;
		end else if (!r_ff.running && enabled && !r_ff.abort && !r_ff.start) begin
			// Back-to-back restart; one idle cycle lets the abort settle first
			nxt_r.start   = 1'b1;
			nxt_r.running = 1'b1;
		end

		// Flag clears on high-byte read or any control write; a completion in
		// the same cycle as a read still wins, except one aborted by the write or by halt
		if (highRead || csrWrite)
			nxt_r.eoc = 1'b0;
		if (bus.done && !(r_ff.running && (chanChange || !enabled ||
				(csrWrite && !csrWdata[ON_POS]))))
			nxt_r.eoc = 1'b1;

		// Settle interval after leaving halt before results are trusted
		if (haltMode) begin
			nxt_r.settleCnt = 16'(SETTLE_CYCLES);
			nxt_r.settled   = 1'b0;
		end else if (r_ff.settleCnt != 16'h0000) begin
			nxt_r.settleCnt = r_ff.settleCnt - 16'h0001;
			nxt_r.settled   = 1'b0;
		end else begin
			nxt_r.settled  = 1'b1;
		end

		nxt_r.csrOut   = csrView;
		nxt_r.hiOut    = nxt_r.res[9:2];
		nxt_r.loOut    = {6'h00, nxt_r.res[1:0]};
		nxt_r.trialOut = bus.trial;
		nxt_r.sampOut  = bus.sampling;
		nxt_r.powerOut = enabled;
	end

	////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge clk) begin
		if (rst) begin
			r_ff <= '0;
			r_ff.settled <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign csrRdata       = r_ff.csrOut;
	assign resultHigh     = r_ff.hiOut;
	assign resultLow      = r_ff.loOut;
	assign channelSel     = r_ff.chan;
	assign converterPower = r_ff.powerOut;
	assign sampleHold     = r_ff.sampOut;
	assign dacTrial       = r_ff.trialOut;
	assign resultSettled  = r_ff.settled;
endmodule

/* File: verif/adc_ctrl_sva.sv */
// Assertions on the converter control ports.
// Assumes one clock and a synchronous reset.
module adc_ctrl_sva (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       csrWrite,
	input wire logic [7:0] csrWdata,
	input wire logic       highRead,
	input wire logic       haltMode,
	input wire logic [7:0] csrRdata,
	input wire logic [2:0] channelSel,
	input wire logic       converterPower,
	input wire logic       sampleHold,
	input wire logic       resultSettled
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	chk_chan_follows: assert property (csrWrite |-> ##1
		channelSel == $past(csrWdata[2:0])) else $error("channel mismatch");
	chk_on_follows: assert property (csrWrite |-> ##2
		csrRdata[5] == $past(csrWdata[5], 2)) else $error("on bit mismatch");
	chk_power_follows: assert property (!haltMode [*3] |->
		converterPower == csrRdata[5]) else $error("power mismatch");
	chk_read_clears: assert property (highRead && csrRdata[7] |->
		##[1:3] !csrRdata[7]) else $error("flag kept after read");
	chk_write_clears: assert property (csrWrite && csrRdata[7] |->
		##[1:3] !csrRdata[7]) else $error("flag kept after write");
	chk_flag_needs_on: assert property ($rose(csrRdata[7]) |->
		csrRdata[5]) else $error("flag set while off");
	chk_off_idle: assert property (!converterPower [*6] |->
		!sampleHold) else $error("sampling while off");
	chk_halt_off: assert property (haltMode [*3] |->
		!converterPower && !resultSettled) else $error("halt not honoured");
endmodule

bind adc_conversion_control adc_ctrl_sva chk (.clk, .rst, .csrWrite, .csrWdata,
	.highRead, .haltMode, .csrRdata, .channelSel, .converterPower, .sampleHold,
	.resultSettled);

/* File: verif/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the block alone; the comparator is modelled from an integer input.
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk = 0, rst = 1, csrWrite = 0, csrRead = 0;
	logic       highRead = 0, lowRead = 0, waitMode = 0, haltMode = 0;
	logic [7:0] csrWdata = 8'h00, csrRdata, resultHigh, resultLow;
	logic [2:0] channelSel;
	logic [9:0] dacTrial;
	logic       converterPower, sampleHold, resultSettled;
	wire        cmpHighAsync;
	int         n_fail = 0, n_compared = 0, av = 0;
	logic [31:0] lfsrState = 32'ha84a;
	// Half-step input so a trial equal to the input never ties
	assign cmpHighAsync = 2 * av + 1 > 2 * int'(dacTrial);
	always #2 clk = ~clk;
	adc_conversion_control #(.SETTLE_CYCLES(10)) DUT (.clk, .rst, .csrWrite,
		.csrWdata, .csrRead, .highRead, .lowRead, .waitMode, .haltMode,
		.cmpHighAsync, .csrRdata, .resultHigh, .resultLow, .channelSel,
		.converterPower, .sampleHold, .dacTrial, .resultSettled);
	////////////////////////////////////////
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(string nm, logic [9:0] e, logic [9:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic step(int n);
		repeat (n) @(posedge clk) #1;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask
	task automatic wr(logic [7:0] d);
		csrWdata = d;
		pulse(csrWrite);
		step(1);
	endtask
	task automatic waitEoc(int lim);
		repeat (lim) if (csrRdata[7] !== 1'b1) step(1);
		chk("eoc", 1, csrRdata[7]);
	endtask
	task automatic readCheck();
		int e;
		e = av < 0 ? 0 : (av > 1023 ? 1023 : av);
		pulse(lowRead);
		chk("low", 10'(e % 4), resultLow);
		pulse(highRead);
		chk("high", 10'(e / 4), resultHigh);
		step(3);
		chk("eocRead", 0, csrRdata[7]);
	endtask
	task automatic complete_run();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		#40000;
		n_fail++;
		complete_run();
	end
	initial begin
		step(8);
		rst = 0;
		chk("rdata", 0, csrRdata);
		chk("settled", 1, resultSettled);
		for (int i = 0; i < 8; i++) begin
			lfsrState = lfsr(lfsrState);
			av = i == 0 ? 1500 : (i == 1 ? -5 : int'(lfsrState[9:0]));
			waitMode = i[0];
			wr(8'h20 | 8'(i));
			chk("chan", 10'(i), channelSel);
			waitEoc(300);
			readCheck();
			waitEoc(150);
			readCheck();
		end
		wr(8'h21);
		waitEoc(300);
		step(30);
		av = 77;
		wr(8'h26);
		chk("eocAbort", 0, csrRdata[7]);
		chk("chanAbort", 10'h006, channelSel);
		step(80);
		chk("eocRestart", 0, csrRdata[7]);
		waitEoc(300);
		readCheck();
		waitEoc(150);
		wr(8'h26);
		chk("eocWrite", 0, csrRdata[7]);
		wr(8'h06);
		step(200);
		chk("power", 0, converterPower);
		chk("eocOff", 0, csrRdata[7]);
		wr(8'h26);
		haltMode = 1;
		step(150);
		chk("haltPwr", 0, converterPower);
		chk("settle", 0, resultSettled);
		chk("eocHalt", 0, csrRdata[7]);
		haltMode = 0;
		step(14);
		chk("settle", 1, resultSettled);
		waitEoc(300);
		readCheck();
		waitEoc(150);
		pulse(highRead);
		chk("high8", 10'(av / 4), resultHigh);
		step(3);
		chk("eoc8", 0, csrRdata[7]);
		complete_run();
	end
endmodule
